// *** apet_pkg.sv ***
// Purpose: Constants, field layouts and carrier types for the auxiliary edge-timing block.
// Assumes: APB register access, one 25 MHz clock, 12-bit edge times in 5 ns steps.
// Notes: Register indices are word indices; the byte address is four times the index.
package apet_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] IDX_SR2_FALL_TIME_HI = 8'h57;
  localparam logic [7:0] IDX_SR2_FALL_EDGE_CFG = 8'h58;
  localparam logic [7:0] IDX_AUX_RISE_EDGE_TIME_HI = 8'h59;
  localparam logic [7:0] IDX_AUX_RISE_EDGE_CFG = 8'h5a;
  localparam logic [7:0] IDX_AUX_FALL_EDGE_TIME_HI = 8'h5b;
  localparam logic [7:0] IDX_AUX_FALL_EDGE_CFG = 8'h5c;
  localparam logic [7:0] IDX_OUT_DISABLE_CFG = 8'h5d;
  localparam logic [7:0] IDX_PERIOD_CFG = 8'h70;
  localparam logic [7:0] IDX_TIMING_STATUS = 8'h71;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int CFG_REGULATE_AUX_BIT = 1;
  localparam int DIS_AUX_BIT = 7;
  localparam int DIS_LATCH_BIT = 0;
  localparam logic [7:0] REG8_RST = 8'h00;
  localparam logic [7:0] OUT_DISABLE_RST = 8'h80;
  localparam logic [11:0] PERIOD_RST = 12'hc80;
  localparam logic [11:0] EDGE_MAX = 12'hfff;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int EDGE_STEP_PS = 5000;
  localparam int CLK_PERIOD_PS = 40000;
  localparam logic [12:0] STEPS_PER_CLK = 13'(CLK_PERIOD_PS / EDGE_STEP_PS);

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  typedef struct packed {
    logic [3:0] time_lo;
    logic mod_en;
    logic sign;
    logic [1:0] misc;
  } apet_edge_cfg_t;

  typedef struct packed {
    logic [7:0] sr2_hi;
    apet_edge_cfg_t sr2_cfg;
    logic [7:0] rise_hi;
    apet_edge_cfg_t rise_cfg;
    logic [7:0] fall_hi;
    apet_edge_cfg_t fall_cfg;
    logic [7:0] out_dis;
    logic [11:0] period;
  } apet_timing_t;

  localparam apet_timing_t TIMING_RST = '{
    sr2_hi: REG8_RST, sr2_cfg: REG8_RST, rise_hi: REG8_RST, rise_cfg: REG8_RST,
    fall_hi: REG8_RST, fall_cfg: REG8_RST, out_dis: OUT_DISABLE_RST, period: PERIOD_RST};

endpackage

// *** apet_top.sv ***
// Purpose: Edge timing for the auxiliary drive output and the second rectifier falling edge.
// Assumes: APB master per the protocol; loop modulation arrives on loop_mod_i in 5 ns steps.
// Notes: Edges resolve to one 40 ns clock; an edge fires in the clock whose 8-step span holds it.
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
module apet_top
  import apet_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [9:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  input wire logic [11:0] loop_mod_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic auxiliary_drive_o,
  output logic rectifier2_fall_o,
  output logic period_start_o,
  output logic blank_sync_o,
  output logic regulate_aux_o
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [11:0] eff_edge(input logic [7:0] hi, input apet_edge_cfg_t cfg,
                                           input logic allow, input logic [11:0] mod);
    logic [12:0] base;
    logic [12:0] sum;
    base = {1'b0, hi, cfg.time_lo};
    sum = base + {1'b0, mod};
    eff_edge = base[11:0];
    if (cfg.mod_en && allow) begin
      if (cfg.sign) begin
        eff_edge = sum[12] ? EDGE_MAX : sum[11:0];
      end else begin
        eff_edge = (base < {1'b0, mod}) ? 12'h000 : 12'(base - {1'b0, mod});
      end
    end
  endfunction

  function automatic logic edge_hit(input logic [11:0] edge_t, input logic [11:0] now);
    edge_hit = ({1'b0, edge_t} >= {1'b0, now}) && ({1'b0, edge_t} < ({1'b0, now} + STEPS_PER_CLK));
  endfunction

  function automatic logic idx_mapped(input logic [7:0] idx);
    idx_mapped = (idx >= IDX_SR2_FALL_TIME_HI && idx <= IDX_OUT_DISABLE_CFG) ||
                 idx == IDX_PERIOD_CFG || idx == IDX_TIMING_STATUS;
  endfunction

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic rst_meta_reg;
  logic rst_sync_reg;
  logic rst_n;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  assign rst_n = rst_sync_reg;

  // ****************************************************************
  // APB slave
  // ****************************************************************
  // Every access gets exactly one wait state so that read data and error come from flip-flops.
  logic [7:0] idx;
  logic access;
  logic first_access;
  logic wr_fire;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic [31:0] rd_value;
  apet_timing_t shadow_reg;
  apet_timing_t shadow_next;
  apet_timing_t active_reg;
  logic latch_go;
  logic [11:0] time_reg;
  logic aux_reg;

  assign idx = paddr_i[9:2];
  assign access = psel_i && penable_i;
  assign first_access = access && !pready_reg;
  assign wr_fire = access && pready_reg && pwrite_i && !pslverr_reg;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= first_access;
      pslverr_reg <= first_access && (!idx_mapped(idx) || paddr_i[1:0] != 2'b00);
    end
  end

  // Misc bits are stored and read back; only fall-edge misc bit 1 is used, as the regulate-with-aux select.
  always_comb begin
    rd_value = 32'h0000_0000;
    case (idx)
      IDX_SR2_FALL_TIME_HI: rd_value[7:0] = shadow_reg.sr2_hi;
      IDX_SR2_FALL_EDGE_CFG: rd_value[7:0] = shadow_reg.sr2_cfg;
      IDX_AUX_RISE_EDGE_TIME_HI: rd_value[7:0] = shadow_reg.rise_hi;
      IDX_AUX_RISE_EDGE_CFG: rd_value[7:0] = shadow_reg.rise_cfg;
      IDX_AUX_FALL_EDGE_TIME_HI: rd_value[7:0] = shadow_reg.fall_hi;
      IDX_AUX_FALL_EDGE_CFG: rd_value[7:0] = shadow_reg.fall_cfg;
      IDX_OUT_DISABLE_CFG: rd_value[7:0] = {shadow_reg.out_dis[7:1], 1'b0};
      IDX_PERIOD_CFG: rd_value[11:0] = shadow_reg.period;
      IDX_TIMING_STATUS: rd_value[13:0] = {aux_reg, regulate_aux_o, time_reg};
      default: rd_value = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      prdata_reg <= 32'h0000_0000;
    end else begin
      prdata_reg <= (first_access && !pwrite_i) ? rd_value : 32'h0000_0000;
    end
  end

  assign pready_o = pready_reg;
  assign pslverr_o = pslverr_reg;
  assign prdata_o = prdata_reg;

  // ****************************************************************
  // Shadow and active timing sets
  // ****************************************************************
  always_comb begin
    shadow_next = shadow_reg;
    if (wr_fire && pstrb_i[0]) begin
      case (idx)
        IDX_SR2_FALL_TIME_HI: shadow_next.sr2_hi = pwdata_i[7:0];
        IDX_SR2_FALL_EDGE_CFG: shadow_next.sr2_cfg = pwdata_i[7:0];
        IDX_AUX_RISE_EDGE_TIME_HI: shadow_next.rise_hi = pwdata_i[7:0];
        IDX_AUX_RISE_EDGE_CFG: shadow_next.rise_cfg = pwdata_i[7:0];
        IDX_AUX_FALL_EDGE_TIME_HI: shadow_next.fall_hi = pwdata_i[7:0];
        IDX_AUX_FALL_EDGE_CFG: shadow_next.fall_cfg = pwdata_i[7:0];
        IDX_OUT_DISABLE_CFG: shadow_next.out_dis = {pwdata_i[7:1], 1'b0};
        IDX_PERIOD_CFG: shadow_next.period[7:0] = pwdata_i[7:0];
        default: shadow_next = shadow_reg;
      endcase
    end
    if (wr_fire && pstrb_i[1] && idx == IDX_PERIOD_CFG) begin
      shadow_next.period[11:8] = pwdata_i[11:8];
    end
  end

  assign latch_go = wr_fire && pstrb_i[0] && idx == IDX_OUT_DISABLE_CFG && pwdata_i[DIS_LATCH_BIT];

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      shadow_reg <= TIMING_RST;
    end else begin
      shadow_reg <= shadow_next;
    end
  end

  // The whole set moves at once on the latch write, not at a period start, so the period it lands in can mix old and new edges.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      active_reg <= TIMING_RST;
    end else if (latch_go) begin
      active_reg <= shadow_next;
    end
  end

  // ****************************************************************
  // Effective edge times
  // ****************************************************************
  logic regulate_aux;
  logic [11:0] rise_eff;
  logic [11:0] fall_eff;
  logic [11:0] sr2_eff;
  logic rise_hit;
  logic fall_hit;
  logic sr2_hit;
  logic aux_dis;
  logic wrap;
  logic aux_next;

  assign regulate_aux = active_reg.fall_cfg[CFG_REGULATE_AUX_BIT];
  // Loop modulation goes to the aux edges only in regulate-with-aux mode, else to the rectifier.
  assign rise_eff = eff_edge(active_reg.rise_hi, active_reg.rise_cfg, regulate_aux, loop_mod_i);
  assign fall_eff = eff_edge(active_reg.fall_hi, active_reg.fall_cfg, regulate_aux, loop_mod_i);
  assign sr2_eff = eff_edge(active_reg.sr2_hi, active_reg.sr2_cfg, !regulate_aux, loop_mod_i);
  assign rise_hit = edge_hit(rise_eff, time_reg);
  assign fall_hit = edge_hit(fall_eff, time_reg);
  assign sr2_hit = edge_hit(sr2_eff, time_reg);
  assign aux_dis = active_reg.out_dis[DIS_AUX_BIT];

  // ****************************************************************
  // Period time base
  // ****************************************************************
  // Time counts 5 ns steps, eight per clock; an edge past the 8-step span of the last clock before wrap never fires.
  assign wrap = ({1'b0, time_reg} + STEPS_PER_CLK) >= {1'b0, active_reg.period};

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      time_reg <= 12'h000;
      period_start_o <= 1'b0;
    end else begin
      time_reg <= wrap ? 12'h000 : 12'(time_reg + STEPS_PER_CLK[11:0]);
      period_start_o <= wrap;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // A fall in the same clock as the rise wins, giving a zero-width pulse rather than a stuck high.
  always_comb begin
    aux_next = aux_reg;
    if (aux_dis) begin
      aux_next = 1'b0;
    end else if (fall_hit) begin
      aux_next = 1'b0;
    end else if (rise_hit) begin
      aux_next = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      aux_reg <= 1'b0;
      rectifier2_fall_o <= 1'b0;
      blank_sync_o <= 1'b0;
      regulate_aux_o <= 1'b0;
    end else begin
      aux_reg <= aux_next;
      rectifier2_fall_o <= sr2_hit;
      blank_sync_o <= regulate_aux ? (aux_next && !aux_reg) : wrap;
      regulate_aux_o <= regulate_aux;
    end
  end
  assign auxiliary_drive_o = aux_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  logic [11:0] rise_base;
  logic [11:0] fall_base;
  logic [11:0] sr2_base;
  logic chk_en_reg;
  assign rise_base = {active_reg.rise_hi, active_reg.rise_cfg.time_lo};
  assign fall_base = {active_reg.fall_hi, active_reg.fall_cfg.time_lo};
  assign sr2_base = {active_reg.sr2_hi, active_reg.sr2_cfg.time_lo};

  // Checks start one clock after reset release, because at the releasing edge the flops still see reset.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      chk_en_reg <= 1'b0;
    end else begin
      chk_en_reg <= 1'b1;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!chk_en_reg);

  a_apb_one_wait: assert property (first_access |=> pready_o ##1 !pready_o)
    else $error("apb answer not after one wait state");
  a_shadow_hold: assert property (!latch_go |=> $stable(active_reg))
    else $error("active timing changed without latch");
  a_latch_apply: assert property (latch_go |=> active_reg == $past(shadow_next))
    else $error("latch did not apply shadow set");
  a_aux_rise_set: assert property (rise_hit && !fall_hit && !aux_dis |=> auxiliary_drive_o)
    else $error("aux did not rise at its edge");
  a_aux_fall_clear: assert property (fall_hit |=> !auxiliary_drive_o)
    else $error("aux did not fall at its edge");
  a_sr2_fall_pulse: assert property (sr2_hit |=> rectifier2_fall_o)
    else $error("rectifier fall pulse missing");
  a_time_step: assert property (!wrap |=> time_reg == $past(time_reg) + 12'h008)
    else $error("time base did not advance eight steps");
  a_fixed_edge: assert property (!(active_reg.rise_cfg.mod_en && regulate_aux) |-> rise_eff == rise_base)
    else $error("unmodulated rise edge moved");
  a_sign_later: assert property (active_reg.rise_cfg.mod_en && regulate_aux && active_reg.rise_cfg.sign
                                 |-> rise_eff >= rise_base)
    else $error("positive modulation moved edge earlier");
  a_sign_earlier: assert property (active_reg.rise_cfg.mod_en && regulate_aux && !active_reg.rise_cfg.sign
                                   |-> rise_eff <= rise_base)
    else $error("negative modulation moved edge later");
  a_blank_aux_sync: assert property (regulate_aux && $rose(auxiliary_drive_o) && $stable(regulate_aux)
                                     |-> blank_sync_o)
    else $error("blanking not synchronized to aux");
  a_blank_normal: assert property (!regulate_aux && wrap |=> blank_sync_o && period_start_o)
    else $error("blanking not on period start in normal mode");
  a_aux_disabled: assert property (aux_dis |=> !auxiliary_drive_o)
    else $error("aux driven while disabled");
  a_fall_fixed: assert property (!(active_reg.fall_cfg.mod_en && regulate_aux) |-> fall_eff == fall_base)
    else $error("unmodulated fall edge moved");
  a_sr2_fixed_regulate: assert property (regulate_aux |-> sr2_eff == sr2_base)
    else $error("rectifier edge modulated in regulate mode");
  a_sr2_mod_normal: assert property (!regulate_aux && active_reg.sr2_cfg.mod_en && active_reg.sr2_cfg.sign &&
                                     sr2_base < 12'h800 && loop_mod_i < 12'h800
                                     |-> sr2_eff == 12'(sr2_base + loop_mod_i))
    else $error("rectifier edge not moved later in normal mode");
  a_wrap_restart: assert property (wrap |=> time_reg == 12'h000 && period_start_o)
    else $error("time base did not restart at period end");
  a_period_pulse: assert property (period_start_o |-> time_reg == 12'h000)
    else $error("period pulse away from period start");
  a_error_with_ready: assert property (pslverr_o |-> pready_o)
    else $error("slave error outside ready");
  a_rdata_idle: assert property (!pready_o |-> prdata_o == 32'h0000_0000)
    else $error("read data shown outside ready");

  c_latch_go: cover property (latch_go);
  c_aux_pulse: cover property ($rose(auxiliary_drive_o) ##[1:400] $fell(auxiliary_drive_o));
  c_regulate_mode: cover property (regulate_aux && blank_sync_o);
  c_sr2_mod: cover property (!regulate_aux && active_reg.sr2_cfg.mod_en && rectifier2_fall_o);
  c_aux_off: cover property (aux_dis && rectifier2_fall_o);

endmodule

// *** aux_pwm_edge_timing_bench.sv ***
// Purpose: Self-checking bench for the auxiliary edge-timing block, driven over APB.
// Assumes: The APB slave answers within 20 clocks; a 40 ns clock; the default period of 400 clocks.
// Notes: Edge moments are counted in clocks after the period pulse, so each lands E/8+1 clocks later.
`timescale 1ns/1ps
module aux_pwm_edge_timing_bench import apet_pkg::*;;
  logic clk_i = 1'b0;
  logic resetn_i;
  logic psel_i;
  logic penable_i;
  logic pwrite_i;
  logic [9:0] paddr_i;
  logic [31:0] pwdata_i;
  logic [3:0] pstrb_i;
  logic [11:0] loop_mod_i;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic auxiliary_drive_o;
  logic rectifier2_fall_o;
  logic period_start_o;
  logic blank_sync_o;
  logic regulate_aux_o;
  int miscompares = 0;
  int checks_done = 0;
  int r;
  int f;
  int s;
  int b;
  logic [31:0] rdat;
  logic [7:0] pat;
  logic err;

  apet_top uut (.clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
    .loop_mod_i(loop_mod_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .auxiliary_drive_o(auxiliary_drive_o), .rectifier2_fall_o(rectifier2_fall_o),
    .period_start_o(period_start_o), .blank_sync_o(blank_sync_o), .regulate_aux_o(regulate_aux_o));

  always #20 clk_i = ~clk_i;

  // ****************************************************************
  // Checking and bus tasks
  // ****************************************************************
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // The request is held until pready is seen at a rising edge, so no wait count is assumed.
  task automatic apb(input logic wr, input logic [9:0] a, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= {24'h000000, d};
    @(posedge clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    rdat = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    if (n >= 20) begin
      miscompares++;
      close_out();
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, {idx, 2'b00}, d);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, {idx, 2'b00}, 8'h00);
    chk(what, rdat, exp);
  endtask

  function automatic int cyc(input logic [11:0] e);
    return int'(e / 12'h008) + 1;
  endfunction

  // ****************************************************************
  // Period measurement
  // ****************************************************************
  // One whole period is skipped first, because a latch in mid-period leaves it partly old.
  task automatic edges(input int er, input int ef, input int es);
    int n;
    r = -1;
    f = -1;
    s = -1;
    b = -1;
    for (int k = 0; k < 2; k++) begin
      n = 0;
      do begin
        @(negedge clk_i);
        n++;
      end while (period_start_o !== 1'b1 && n < 1000);
      if (n >= 1000) begin
        miscompares++;
        close_out();
      end
    end
    for (n = 1; n < 400; n++) begin
      @(negedge clk_i);
      if (auxiliary_drive_o === 1'b1 && r < 0) r = n;
      if (auxiliary_drive_o === 1'b0 && r >= 0 && f < 0) f = n;
      if (rectifier2_fall_o === 1'b1 && s < 0) s = n;
      if (blank_sync_o === 1'b1 && b < 0) b = n;
    end
    chk("aux rise clock", 32'(r), 32'(er));
    chk("aux fall clock", 32'(f), 32'(ef));
    chk("rectifier2 fall clock", 32'(s), 32'(es));
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    resetn_i = 1'b0;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 10'h000;
    pwdata_i = 32'h00000000;
    pstrb_i = 4'hf;
    loop_mod_i = 12'h000;
    repeat (20) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    for (int i = 'h57; i <= 'h5c; i++) rd_chk("timing reset", 8'(i), 32'h00000000);
    rd_chk("disable reset", IDX_OUT_DISABLE_CFG, 32'h00000080);
    rd_chk("period reset", IDX_PERIOD_CFG, {20'h00000, PERIOD_RST});
    apb(1'b0, 10'h040, 8'h00);
    chk("unmapped error", {31'h0, err}, 32'h1);
    chk("unmapped data", rdat, 32'h0);
    apb(1'b1, 10'h171, 8'hfe);
    chk("misaligned error", {31'h0, err}, 32'h1);
    rd_chk("misaligned ignored", IDX_AUX_FALL_EDGE_CFG, 32'h0);
    for (int i = 'h57; i <= 'h5c; i++) begin
      // Setting registers sit at the even indices; their misc low bits stay zero.
      pat = (8'(i) ^ 8'ha5) & (i[0] ? 8'hff : 8'hfc);
      wr(8'(i), pat);
      rd_chk("readback", 8'(i), {24'h0, pat});
    end
    // Reserved bit 0 is kept at zero in every setting written below; fall-setting bit 1 selects regulate mode.
    wr(IDX_SR2_FALL_TIME_HI, 8'h20);
    wr(IDX_SR2_FALL_EDGE_CFG, 8'hf0);
    wr(IDX_AUX_RISE_EDGE_TIME_HI, 8'h12);
    wr(IDX_AUX_RISE_EDGE_CFG, 8'hf0);
    wr(IDX_AUX_FALL_EDGE_TIME_HI, 8'h45);
    wr(IDX_AUX_FALL_EDGE_CFG, 8'hf0);
    wr(IDX_OUT_DISABLE_CFG, 8'h00);
    edges(-1, -1, cyc(12'h000));
    wr(IDX_OUT_DISABLE_CFG, 8'h01);
    rd_chk("latch bit reads zero", IDX_OUT_DISABLE_CFG, 32'h0);
    edges(cyc(12'h12f), cyc(12'h45f), cyc(12'h20f));
    chk("normal mode", {31'h0, regulate_aux_o}, 32'h0);
    @(posedge clk_i);
    loop_mod_i <= 12'h040;
    wr(IDX_AUX_RISE_EDGE_CFG, 8'hfc);
    wr(IDX_SR2_FALL_EDGE_CFG, 8'hfc);
    wr(IDX_OUT_DISABLE_CFG, 8'h01);
    edges(cyc(12'h12f), cyc(12'h45f), cyc(12'h24f));
    chk("blank apart from aux", 32'(b == r), 32'h0);
    wr(IDX_AUX_FALL_EDGE_CFG, 8'hf2);
    wr(IDX_OUT_DISABLE_CFG, 8'h01);
    edges(cyc(12'h16f), cyc(12'h45f), cyc(12'h20f));
    chk("regulate mode", {31'h0, regulate_aux_o}, 32'h1);
    chk("blank on aux rise", 32'(b), 32'(cyc(12'h16f)));
    wr(IDX_AUX_RISE_EDGE_CFG, 8'hf8);
    wr(IDX_AUX_FALL_EDGE_CFG, 8'hfa);
    wr(IDX_OUT_DISABLE_CFG, 8'h01);
    edges(cyc(12'h0ef), cyc(12'h41f), cyc(12'h20f));
    wr(IDX_AUX_FALL_EDGE_CFG, 8'hfe);
    wr(IDX_OUT_DISABLE_CFG, 8'h01);
    edges(cyc(12'h0ef), cyc(12'h49f), cyc(12'h20f));
    wr(IDX_OUT_DISABLE_CFG, 8'h81);
    edges(-1, -1, cyc(12'h20f));
    wr(IDX_PERIOD_CFG, 8'h80);
    rd_chk("period readback", IDX_PERIOD_CFG, 32'h00000080);
    close_out();
  end
endmodule
